// [logic/qio_top.v]
// Quadrature A/B/Z output generator with interpolation of tooth edges
`timescale 1ns/100ps
`default_nettype none
`include "qio_consts.vh"
module qio_top (
  // Clock and reset
  input wire REF_CLK,
  input wire RSTN,
  // Sensed tooth signal, index tooth mark and direction of rotation
  input wire TOOTH_IN,
  input wire INDEX_MARK_IN,
  input wire DIR_REV_IN,
  // Configuration: interpolation factor (1..256) and tooth count
  input wire [8:0] INTERP,
  input wire [9:0] TEETH,
  // Quadrature outputs with complements
  output reg A_OUT,
  output reg A_N_OUT,
  output reg B_OUT,
  output reg B_N_OUT,
  output reg Z_OUT,
  output reg Z_N_OUT,
  // Revolution marker, pulsed for one cycle with each index pulse
  output reg REV_PULSE
);
  ////////////////////////////////////////////////////////////////////////
  // Input conditioning
  wire tooth_s;
  wire mark_s;
  wire dir_s;
  // Tooth edges from the sensor
  qio_sync u_sync_tooth (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .din(TOOTH_IN),
    .dout(tooth_s)
  );
  // Index tooth mark
  qio_sync u_sync_mark (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .din(INDEX_MARK_IN),
    .dout(mark_s)
  );
  // Direction of rotation
  qio_sync u_sync_dir (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .din(DIR_REV_IN),
    .dout(dir_s)
  );

  // Clamp factor into 1..256
  function [8:0] qio_clamp;
    input [8:0] f;
    begin
      if (f == 9'h0_000) begin
        qio_clamp = 9'h0_001;
      end else if (f > `QIO_INTERP_MAX) begin
        qio_clamp = `QIO_INTERP_MAX;
      end else begin
        qio_clamp = f;
      end
    end
  endfunction

  // Gray phase to A,B levels
  function [1:0] qio_ab;
    input [1:0] ph;
    begin
      case (ph)
        `QIO_PH0: qio_ab = 2'h0;
        `QIO_PH1: qio_ab = 2'h2;
        `QIO_PH2: qio_ab = 2'h3;
        default: qio_ab = 2'h1;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Tooth period measurement
  reg tooth_d1_q;
  reg tooth_seen_q;
  reg [23:0] per_cnt_q;
  reg [23:0] tooth_per_q;
  reg per_valid_q;
  reg [8:0] interp_q;
  wire tooth_rise;
  wire per_full;
  assign tooth_rise = tooth_s & ~tooth_d1_q;
  // Period counter saturated: gear counts as stopped
  assign per_full = (per_cnt_q == `QIO_STALL_MAX);
  // Measure clocks per tooth, latch factor at each tooth
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tooth_d1_q <= 1'b0;
      tooth_seen_q <= 1'b0;
      per_cnt_q <= 24'h00_0000;
      tooth_per_q <= 24'h00_0000;
      per_valid_q <= 1'b0;
      interp_q <= 9'h0_001;
    end else begin
      tooth_d1_q <= tooth_s;
      if (tooth_rise) begin
        tooth_seen_q <= 1'b1;
        tooth_per_q <= per_cnt_q;
        per_cnt_q <= 24'h00_0001;
        // First rise and a rise after a stall only start the count
        per_valid_q <= tooth_seen_q && !per_full;
        interp_q <= qio_clamp(INTERP); // RULE9
      end else if (!per_full) begin
        per_cnt_q <= per_cnt_q + 24'h00_0001;
      end else begin
        per_valid_q <= 1'b0; // Gear stopped: halt outputs
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Quarter step rate: 4*interp steps per tooth period (DDA)
  reg [33:0] acc_q;
  reg [10:0] steps_q;
  wire [10:0] steps_per_tooth;
  wire [33:0] add_w;
  wire [33:0] lim_w;
  wire [33:0] acc_sum_w;
  wire step_en;
  assign steps_per_tooth = {interp_q, 2'b00};
  assign add_w = {23'h00_0000, steps_per_tooth};
  assign lim_w = {10'h000, tooth_per_q};
  // Accumulator after this cycle's add, shared by test and update
  assign acc_sum_w = acc_q + add_w;
  assign step_en = per_valid_q && (acc_sum_w >= lim_w)
                   && (steps_q < steps_per_tooth);
  // Accumulate steps so rate = teeth*interp*rpm/60*4 edges
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      acc_q <= 34'h0_0000_0000;
      steps_q <= 11'h000;
    end else if (tooth_rise) begin
      acc_q <= 34'h0_0000_0000;
      steps_q <= 11'h000;
    end else if (per_valid_q) begin
      if (step_en) begin
        acc_q <= acc_sum_w - lim_w; // RULE3 RULE6
        steps_q <= steps_q + 11'h001;
      end else begin
        acc_q <= acc_sum_w;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Index mark lockout: one index per revolution of TEETH teeth
  reg [9:0] since_mark_q;
  wire mark_ok;
  // Accept a mark only once a full revolution of teeth has gone by
  assign mark_ok = ({1'b0, since_mark_q} + 11'h001 >= {1'b0, TEETH}); // RULE11
  // Count teeth since the last accepted mark, saturating
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      since_mark_q <= `QIO_TEETH_SAT;
    end else if (tooth_rise) begin
      if (mark_s && mark_ok) begin
        since_mark_q <= 10'h000;
      end else if (since_mark_q != `QIO_TEETH_SAT) begin
        since_mark_q <= since_mark_q + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Phase sequencing and index placement
  reg [1:0] phase_q;
  reg [1:0] phase_d;
  reg mark_armed_q;
  reg [1:0] ab_d;
  always @* begin
    phase_d = phase_q;
    if (step_en) begin
      phase_d = dir_s ? phase_q - 2'h1 : phase_q + 2'h1; // RULE10 RULE4
    end
    ab_d = qio_ab(phase_d);
  end
  // Drive outputs; index spans one quarter step at a fixed phase
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      phase_q <= `QIO_PH0;
      mark_armed_q <= 1'b0;
      A_OUT <= 1'b0;
      A_N_OUT <= 1'b1;
      B_OUT <= 1'b0;
      B_N_OUT <= 1'b1;
      Z_OUT <= 1'b0;
      Z_N_OUT <= 1'b1;
      REV_PULSE <= 1'b0;
    end else begin
      phase_q <= phase_d;
      A_OUT <= ab_d[1]; // RULE1 RULE5
      A_N_OUT <= ~ab_d[1];
      B_OUT <= ab_d[0];
      B_N_OUT <= ~ab_d[0];
      REV_PULSE <= 1'b0;
      // Index stands until the next quarter step
      if (step_en) begin
        if (mark_armed_q && phase_d == `QIO_INDEX_PHASE) begin
          Z_OUT <= 1'b1; // RULE11 RULE2
          Z_N_OUT <= 1'b0;
          REV_PULSE <= 1'b1;
          mark_armed_q <= 1'b0;
        end else begin
          Z_OUT <= 1'b0;
          Z_N_OUT <= 1'b1;
        end
      end
      // A fresh mark beats the clear of an index just sent
      if (mark_s && tooth_rise && mark_ok) begin
        mark_armed_q <= 1'b1; // RULE11
      end
    end
  end
endmodule // qio_top
`default_nettype wire

// [logic/qio_consts.vh]
// Constants for the quadrature index output generator
// Summary of operation
// RULE1: Two complementary square channels, ninety degrees apart
// RULE2: Index pulse, complemented, one quarter period wide
// RULE3: Period is tooth pitch over interpolation factor
// RULE4: Each edge-to-edge interval lasts quarter period
// RULE5: Each channel high and low half period
// RULE6: Output rate is teeth times factor times rpm/60
// RULE7: Tool monitors pulses, direction and revolution count
// RULE8: Tool calibrates offset and phase, reports interpolation
// RULE9: Interpolation factor up to 256 per tooth
// RULE10: Leading channel conveys rotation direction
// RULE11: Index once per revolution at fixed quadrature position
`ifndef QIO_CONSTS_VH
`define QIO_CONSTS_VH
// Interpolation factor limit and field width
`define QIO_INTERP_MAX 9'h0_100
`define QIO_INTERP_W 9
// Tooth count field width
`define QIO_TEETH_W 10
// Position within one interpolated period: four quarter steps
`define QIO_PHASE_W 2
// Fine position accumulator width (interp step times 4 phases)
`define QIO_FINE_W 11
// Quarter phase codes of the Gray sequence A,B
`define QIO_PH0 2'h0
`define QIO_PH1 2'h1
`define QIO_PH2 2'h2
`define QIO_PH3 2'h3
// Input tooth edge filter: three-flop synchroniser
`define QIO_SYNC_LEN 3
// Phase within a period at which the index pulse sits
`define QIO_INDEX_PHASE 2'h0
// Period count at which the gear counts as stopped
`define QIO_STALL_MAX 24'hFF_FFFF
// Saturated teeth-since-index count, so the first mark is accepted
`define QIO_TEETH_SAT 10'h3FF
`endif

// [logic/qio_sync.v]
// Three-flop synchroniser with agreement check for a pin input
`timescale 1ns/100ps
`default_nettype none
module qio_sync (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Raw pin and filtered level
  input wire din,
  output reg dout
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  // Shift chain; first flop feeds only the second
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q; // Change counts once two and three agree
      end
    end
  end
endmodule // qio_sync
`default_nettype wire

// [tb/qio_chk.sv]
// Checker for the quadrature output generator
`timescale 1ns/100ps
`default_nettype none
module qio_chk (
  // Clock, reset, direction and outputs
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic DIR_REV_IN,
  input wire logic A_OUT,
  input wire logic A_N_OUT,
  input wire logic B_OUT,
  input wire logic B_N_OUT,
  input wire logic Z_OUT,
  input wire logic Z_N_OUT,
  input wire logic REV_PULSE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  // A rise with direction settled
  sequence s_a_up; $rose(A_OUT) && DIR_REV_IN == $past(DIR_REV_IN, 8); endsequence
  AST_A_PAIR: assert property (A_N_OUT != A_OUT) else $error("A pair");
  AST_B_PAIR: assert property (B_N_OUT != B_OUT) else $error("B pair");
  AST_Z_PAIR: assert property (Z_N_OUT != Z_OUT) else $error("Z pair");
  AST_STEP: assert property (!($changed(A_OUT) && $changed(B_OUT))) else $error("AB");
  AST_LEAD: assert property (s_a_up |-> B_OUT == DIR_REV_IN) else $error("lead");
  AST_Z_AT: assert property (Z_OUT |-> !A_OUT && !B_OUT) else $error("Z phase");
  AST_Z_QTR: assert property (Z_OUT && $past(Z_OUT) |-> $stable(A_OUT) && $stable(B_OUT))
    else $error("Z width");
  AST_Z_REV: assert property ($rose(Z_OUT) |-> REV_PULSE) else $error("rev");
  AST_REV_ONE: assert property (REV_PULSE |=> !REV_PULSE) else $error("rev");
endmodule // qio_chk
bind qio_top qio_chk u_chk (.*);
`default_nettype wire

// [tb/qio_far.sv]
// Far-side pulse counter with period meter
`timescale 1ns/100ps
`default_nettype none
module qio_far (
  // Clock, reset and channels
  input wire logic clk,
  input wire logic rst_n,
  input wire logic a,
  input wire logic b,
  input wire logic z,
  // Position, revolutions, period, high time and index width
  output logic [31:0] pos,
  output logic [31:0] revs,
  output logic [31:0] per,
  output logic [31:0] hi,
  output logic [31:0] zw
);
  logic a_q, b_q, z_q;
  logic [31:0] cyc, ar, zr;
  // Count edges by direction, meter channel A
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {a_q, b_q, z_q, cyc, ar, zr, pos, revs, per, hi, zw} <= '0;
    end else begin
      a_q <= a;
      b_q <= b;
      z_q <= z;
      cyc <= cyc + 1;
      if (a != a_q) pos <= (a != b) ? pos + 1 : pos - 1;
      if (b != b_q) pos <= (a == b) ? pos + 1 : pos - 1;
      if (z && !z_q) revs <= revs + 1;
      if (z && !z_q) zr <= cyc;
      if (!z && z_q) zw <= cyc - zr;
      if (!a && a_q) hi <= cyc - ar;
      if (a && !a_q) begin
        per <= cyc - ar;
        ar <= cyc;
      end
    end
  end
endmodule // qio_far
`default_nettype wire

// [tb/qio_top_tb.sv]
// Self-checking bench for the quadrature output generator
`timescale 1ns/100ps
`default_nettype none
module qio_top_tb;
  logic clk = 1'b0, rstn = 1'b0, tooth = 1'b0, mark = 1'b0, dir = 1'b0;
  logic [8:0] interp = 9'h0_004;
  logic [9:0] teeth = 10'h0_004;
  logic a, an, b, bn, z, zn, rev;
  logic [31:0] pos, p0, revs, r0, per, hi, zw;
  int failures = 0, total_checks = 0, cycles = 0, tn = 0;
  always #20 clk = ~clk;
  qio_top DUT (.REF_CLK(clk), .RSTN(rstn), .TOOTH_IN(tooth), .INDEX_MARK_IN(mark),
    .DIR_REV_IN(dir), .INTERP(interp), .TEETH(teeth), .A_OUT(a), .A_N_OUT(an), .B_OUT(b),
    .B_N_OUT(bn), .Z_OUT(z), .Z_N_OUT(zn), .REV_PULSE(rev));
  qio_far u_far (.clk(clk), .rst_n(rstn), .a(a), .b(b), .z(z), .pos(pos), .revs(revs),
    .per(per), .hi(hi), .zw(zw));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Within a fifth of nominal
  function automatic logic [31:0] near(input logic [31:0] v, input int n);
    return {31'h0, (v * 5 >= n * 4) && (v * 5 <= n * 6)};
  endfunction
  // Turn the gear by n teeth of tt cycles, index tooth every TEETH
  task automatic spin(input int n, input int tt);
    repeat (n) begin
      tooth <= 1'b1;
      mark <= (tn % teeth == 0);
      tn++;
      repeat (tt / 2) @(posedge clk);
      tooth <= 1'b0;
      repeat (tt / 2) @(posedge clk);
    end
  endtask
  task automatic run(input logic [8:0] f, input logic d, input int n, input int tt);
    interp <= f;
    dir <= d;
    spin(4, tt);
    p0 = pos;
    r0 = revs;
    spin(n, tt);
  endtask
  task automatic t_fwd();
    run(9'h0_004, 1'b0, 8, 200);
    chk(near(per, 50), 1);
    chk(near(hi * 2, 50), 1);
    chk(near(pos - p0, 128), 1);
    chk(revs - r0, 2);
    chk(near(zw * 4, 50), 1);
  endtask
  // Mid-run reset returns every output to its idle level
  task automatic t_rst();
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk({a, an, b, bn, z, zn, rev}, 7'h2A);
    rstn <= 1'b1;
    @(posedge clk);
  endtask
  task automatic t_rev();
    run(9'h0_004, 1'b1, 8, 200);
    chk(near(p0 - pos, 128), 1);
  endtask
  task automatic t_max();
    run(9'h0_100, 1'b0, 2, 4096);
    chk(near(per, 16), 1);
    chk(near(pos - p0, 2048), 1);
  endtask
  task automatic finish_test();
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_fwd();
    t_rev();
    t_rst();
    t_max();
    finish_test();
  end
endmodule // qio_top_tb
`default_nettype wire
